// ==== rtl/flash_ctrl_consts.vh ====
// Constants for the flash timing and cache control block.
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH

// Register offsets and the page that holds the paged registers.
`define TIMING_SCALE_ADDR     8'hB6
`define STROBE_WIDTH_ADDR     8'hBE
`define CACHE_CTRL_ADDR       8'hE3
`define CONFIG_PAGE           8'h0F

// Field positions.
`define READ_WAIT_BIT         4
`define LONG_PROG_BIT         1
`define PREFETCH_BIT          5
`define PAIR_WRITE_BIT        0
`define PERIOD_MSB            3

// Reset values.
`define TIMING_SCALE_RST      8'h00
`define STROBE_WIDTH_RST      4'hF
`define CACHE_CTRL_RST        8'h20

// Timing: strobe limit is STEP + PERIOD * STEP, clock at 100 MHz.
`define STROBE_STEP_NS        8'd5
`define CLK_PERIOD_NS         8'd10
`define READ_WAIT_MHZ         25

// Erase/write durations in clock cycles.
`define SHORT_PROG_CYCLES     400
`define LONG_PROG_CYCLES      1200

`endif

// ==== rtl/read_strobe_gen.v ====
// Flash read strobe generator with width limit and low-power control.
`timescale 1ns/10ps
`include "flash_ctrl_consts.vh"

module read_strobe_gen (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // Read access request
  input  wire       i_start,
  input  wire       i_two_clk,
  input  wire [3:0] i_period,
  // Flash array side
  output wire       o_strobe,
  output wire       o_low_power,
  output wire       o_busy
);

  reg  [1:0] acc_cnt_ff;
  reg  [1:0] str_cnt_ff;
  wire [1:0] acc_len;
  wire [1:0] limit;
  wire [1:0] str_len;

  // Longest strobe in whole cycles, rounded down, never below one.
  function [1:0] limit_cycles;
    input [3:0] period;
    reg   [7:0] ns;
    reg   [7:0] cyc;
    begin
      ns  = (8'd1 + {4'h0, period}) * `STROBE_STEP_NS;
      cyc = ns / `CLK_PERIOD_NS;
      if (cyc == 8'h00)
        limit_cycles = 2'd1;
      else if (cyc > 8'h02)
        limit_cycles = 2'd2;
      else
        limit_cycles = cyc[1:0];
    end
  endfunction

  assign acc_len = i_two_clk ? 2'd2 : 2'd1; // [R1]
  assign limit   = limit_cycles(i_period); // [R7]
  assign str_len = (limit < acc_len) ? limit : acc_len; // [R7]

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_cnt_ff <= 2'd0;
      str_cnt_ff <= 2'd0;
    end else if (i_start && (acc_cnt_ff == 2'd0)) begin
      acc_cnt_ff <= acc_len; // [R1]
      str_cnt_ff <= str_len;
    end else begin
      if (acc_cnt_ff != 2'd0)
        acc_cnt_ff <= acc_cnt_ff - 2'd1;
      if (str_cnt_ff != 2'd0)
        str_cnt_ff <= str_cnt_ff - 2'd1;
    end
  end

  assign o_strobe    = (str_cnt_ff != 2'd0);
  // Once the strobe drops the array idles for the rest of the access.
  assign o_low_power = ~o_strobe; // [R8]
  assign o_busy      = (acc_cnt_ff != 2'd0);

endmodule // read_strobe_gen

// ==== rtl/flash_timing_cache_ctrl.v ====
// Flash timing, strobe width and cache control registers with their logic.
`timescale 1ns/10ps
`include "flash_ctrl_consts.vh"

// Behaviour
// [R1] A flash read strobe lasts one core clock with read_wait_select clear and two when set.
// [R2] Software should pick the smallest read_wait_select the core clock allows.
// [R3] Software should set long_program_timing before any flash write or erase.
// [R4] Erase and write use short timing when long_program_timing is zero, extended when one.
// [R5] The prefetch engine runs while prefetch_on is one, which it is after reset.
// [R6] Firmware writes program single bytes, or byte pairs when pair_write_on is set.
// [R7] The read strobe is cut to at most 5 ns plus period times 5 ns; period resets to 15. Here period 0 still gives one 10 ns clock.
// [R8] After the strobe drops, the flash sits in low power for the rest of the cycle.
// [R9] Bits 7:4 of the strobe width register read zero and ignore writes.
// [R10] Software writes zeros to reserved bits, which are stored but do nothing.
module flash_timing_cache_ctrl #(
  parameter SHORT_CYCLES = `SHORT_PROG_CYCLES,
  parameter LONG_CYCLES  = `LONG_PROG_CYCLES
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Special-function register port
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_page,
  input  wire        i_sfr_wr,
  input  wire [7:0]  i_sfr_wdata,
  output reg  [7:0]  o_sfr_rdata,
  // Core read requests
  input  wire        i_rd_req,
  output wire        o_rd_busy,
  // Firmware write and erase requests
  input  wire        i_fw_wr,
  input  wire [15:0] i_fw_addr,
  input  wire [7:0]  i_fw_data,
  input  wire        i_erase_req,
  output wire        o_fw_ready,
  // Flash array controls
  output wire        o_rd_strobe,
  output wire        o_low_power,
  output reg         o_prog_start,
  output reg         o_erase_start,
  output reg  [15:0] o_prog_addr,
  output reg  [15:0] o_prog_data,
  output reg         o_prog_pair,
  output wire        o_prog_busy,
  output wire        o_long_program_timing,
  output wire        o_prefetch_on
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file.

  reg  [7:0]  timing_scale_ff;
  reg  [3:0]  strobe_period_ff;
  reg  [7:0]  cache_ctrl_ff;

  // Shared decode of an address against a register and its page.
  function hit;
    input [7:0] addr;
    input [7:0] page;
    input [7:0] want;
    input       any_page;
    begin
      hit = (addr == want) && (any_page || (page == `CONFIG_PAGE));
    end
  endfunction

  wire sel_scale  = hit(i_sfr_addr, i_sfr_page, `TIMING_SCALE_ADDR, 1'b1);
  wire sel_strobe = hit(i_sfr_addr, i_sfr_page, `STROBE_WIDTH_ADDR, 1'b0);
  wire sel_cache  = hit(i_sfr_addr, i_sfr_page, `CACHE_CTRL_ADDR, 1'b0);

  wire read_wait_select    = timing_scale_ff[`READ_WAIT_BIT];
  wire long_program_timing = timing_scale_ff[`LONG_PROG_BIT];
  wire prefetch_on         = cache_ctrl_ff[`PREFETCH_BIT];
  wire pair_write_on       = cache_ctrl_ff[`PAIR_WRITE_BIT];

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timing_scale_ff  <= `TIMING_SCALE_RST;
      strobe_period_ff <= `STROBE_WIDTH_RST; // [R7]
      cache_ctrl_ff    <= `CACHE_CTRL_RST; // [R5]
    end else if (i_sfr_wr) begin
      // Reserved bits are kept as written but steer nothing.
      if (sel_scale)
        timing_scale_ff <= i_sfr_wdata; // [R10]
      if (sel_strobe)
        strobe_period_ff <= i_sfr_wdata[`PERIOD_MSB:0]; // [R9]
      if (sel_cache)
        cache_ctrl_ff <= i_sfr_wdata; // [R10]
    end
  end

  // Read data appear one clock after the address; unmapped reads give zero.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (sel_scale) begin
      o_sfr_rdata <= timing_scale_ff;
    end else if (sel_strobe) begin
      o_sfr_rdata <= {4'h0, strobe_period_ff}; // [R9]
    end else if (sel_cache) begin
      o_sfr_rdata <= cache_ctrl_ff;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  assign o_prefetch_on         = prefetch_on; // [R5]
  assign o_long_program_timing = long_program_timing; // [R4]

  //////////////////////////////////////////////////////////////////////////////
  // Read strobe.

  read_strobe_gen u_strobe (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_start     (i_rd_req),
    .i_two_clk   (read_wait_select),
    .i_period    (strobe_period_ff),
    .o_strobe    (o_rd_strobe),
    .o_low_power (o_low_power),
    .o_busy      (o_rd_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Erase and write sequencing.

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg         state_ff;
  reg  [15:0] prog_cnt_ff;
  reg         half_ff;
  reg  [15:0] half_addr_ff;
  reg  [7:0]  half_data_ff;

  wire [15:0] short_cnt = SHORT_CYCLES[15:0];
  wire [15:0] long_cnt  = LONG_CYCLES[15:0];
  wire [15:0] load_cnt  = long_program_timing ? long_cnt : short_cnt; // [R4]

  assign o_fw_ready  = (state_ff == ST_IDLE);
  assign o_prog_busy = (state_ff == ST_BUSY);

  // The timing bit is sampled at the start, so changing it mid-operation
  // only affects the next one.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff      <= ST_IDLE;
      prog_cnt_ff   <= 16'h0000;
      half_ff       <= 1'b0;
      half_addr_ff  <= 16'h0000;
      half_data_ff  <= 8'h00;
      o_prog_start  <= 1'b0;
      o_erase_start <= 1'b0;
      o_prog_addr   <= 16'h0000;
      o_prog_data   <= 16'h0000;
      o_prog_pair   <= 1'b0;
    end else begin
      o_prog_start  <= 1'b0;
      o_erase_start <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (i_erase_req) begin
            o_erase_start <= 1'b1;
            o_prog_addr   <= i_fw_addr;
            half_ff       <= 1'b0;
            prog_cnt_ff   <= load_cnt; // [R4]
            state_ff      <= ST_BUSY;
          end else if (i_fw_wr) begin
            if (pair_write_on && !half_ff) begin
              half_ff      <= 1'b1; // [R6]
              half_addr_ff <= i_fw_addr;
              half_data_ff <= i_fw_data;
            end else if (pair_write_on) begin
              half_ff      <= 1'b0;
              o_prog_start <= 1'b1;
              o_prog_pair  <= 1'b1; // [R6]
              o_prog_addr  <= half_addr_ff;
              o_prog_data  <= {i_fw_data, half_data_ff};
              prog_cnt_ff  <= load_cnt;
              state_ff     <= ST_BUSY;
            end else begin
              half_ff      <= 1'b0;
              o_prog_start <= 1'b1;
              o_prog_pair  <= 1'b0; // [R6]
              o_prog_addr  <= i_fw_addr;
              o_prog_data  <= {8'h00, i_fw_data};
              prog_cnt_ff  <= load_cnt;
              state_ff     <= ST_BUSY;
            end
          end
        end
        ST_BUSY: begin
          if (prog_cnt_ff <= 16'h0001) begin
            prog_cnt_ff <= 16'h0000;
            state_ff    <= ST_IDLE;
          end else begin
            prog_cnt_ff <= prog_cnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // flash_timing_cache_ctrl

// ==== testbench/flash_ctrl_props.sv ====
// Checker for the flash timing and cache control block.
`timescale 1ns/10ps
module flash_ctrl_props #(
  parameter SHORT_CYCLES = 4,
  parameter LONG_CYCLES  = 8
) (
  input wire       i_clk, i_rst, i_sfr_wr, i_rd_req, o_rd_busy,
  input wire       o_rd_strobe, o_low_power, o_prog_start, o_erase_start,
  input wire       o_prog_pair, o_prog_busy, o_long_program_timing,
  input wire       o_prefetch_on,
  input wire [7:0] i_sfr_addr, i_sfr_page, i_sfr_wdata, o_sfr_rdata
);
  wire      go = i_rd_req && !o_rd_busy;
  wire      hit_b6 = i_sfr_wr && i_sfr_addr == 8'hB6;
  wire      hit_pg = i_sfr_wr && i_sfr_page == 8'h0F;
  reg       rw_ff, pw_ff, lng_ff;
  reg [3:0] per_ff;
  reg [7:0] cnt_ff;
  // Shadow copies of the control bits, so lengths can be predicted.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rw_ff  <= 1'b0;
      pw_ff  <= 1'b0;
      lng_ff <= 1'b0;
      per_ff <= 4'hF;
      cnt_ff <= 8'h00;
    end else begin
      if (hit_b6) rw_ff <= i_sfr_wdata[4];
      if (hit_pg && i_sfr_addr == 8'hE3) pw_ff <= i_sfr_wdata[0];
      if (hit_pg && i_sfr_addr == 8'hBE) per_ff <= i_sfr_wdata[3:0];
      if (o_prog_start || o_erase_start) lng_ff <= o_long_program_timing;
      cnt_ff <= o_prog_busy ? cnt_ff + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_low; o_low_power == !o_rd_strobe; endproperty
  property p_one; go && !rw_ff |=> o_rd_strobe ##1 !o_rd_strobe; endproperty
  property p_two;
    go && rw_ff && per_ff > 4'h2 |=> o_rd_strobe [*2] ##1 !o_rd_strobe;
  endproperty
  property p_cut; go && per_ff < 4'h3 |=> o_rd_strobe ##1 !o_rd_strobe;
  endproperty
  property p_busy;
    $fell(o_prog_busy) |-> cnt_ff == (lng_ff ? LONG_CYCLES : SHORT_CYCLES);
  endproperty
  property p_long;
    hit_b6 |=> o_long_program_timing == $past(i_sfr_wdata[1]);
  endproperty
  property p_pref;
    hit_pg && i_sfr_addr == 8'hE3 |=> o_prefetch_on == $past(i_sfr_wdata[5]);
  endproperty
  property p_upper;
    i_sfr_addr == 8'hBE && i_sfr_page == 8'h0F |=> o_sfr_rdata[7:4] == 4'h0;
  endproperty
  property p_pair; o_prog_start |-> o_prog_pair == pw_ff; endproperty
  a_low: assert property (p_low) else $error("low power wrong");
  a_one: assert property (p_one) else $error("short strobe wrong");
  a_two: assert property (p_two) else $error("long strobe wrong");
  a_cut: assert property (p_cut) else $error("strobe not cut");
  a_busy: assert property (p_busy) else $error("program time wrong");
  a_long: assert property (p_long) else $error("timing bit wrong");
  a_pref: assert property (p_pref) else $error("prefetch bit wrong");
  a_upper: assert property (p_upper) else $error("upper bits set");
  a_pair: assert property (p_pair) else $error("pair flag wrong");
  c_two: cover property (o_rd_strobe [*2]);
  c_pair: cover property (o_prog_start && o_prog_pair);
  c_erase: cover property (o_erase_start);
endmodule // flash_ctrl_props

bind flash_timing_cache_ctrl flash_ctrl_props #(
  .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)
) u_flash_ctrl_props (.*);

// ==== testbench/flash_array_model.sv ====
// Behavioural model of the program flash array fed by the block.
`timescale 1ns/10ps
module flash_array_model (
  input  wire        i_clk,
  input  wire        i_prog_start,
  input  wire        i_erase_start,
  input  wire [15:0] i_prog_addr,
  input  wire [15:0] i_prog_data,
  input  wire        i_prog_pair,
  output reg  [7:0]  o_erases
);
  reg [7:0] mem [0:65535];
  initial o_erases = 8'h00;
  // Erases are only counted; clearing a sector is not modelled.
  always @(posedge i_clk) begin
    if (i_erase_start) o_erases <= o_erases + 8'h01;
    if (i_prog_start) mem[i_prog_addr] <= i_prog_data[7:0];
    if (i_prog_start && i_prog_pair)
      mem[i_prog_addr + 16'h0001] <= i_prog_data[15:8];
  end
endmodule // flash_array_model

// ==== testbench/tb_flash_timing_cache_ctrl.sv ====
// Self-checking bench for the flash timing and cache control block.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_flash_timing_cache_ctrl;
  logic        i_clk = 0, i_rst = 1, i_sfr_wr = 0, i_rd_req = 0;
  logic        i_fw_wr = 0, i_erase_req = 0, o_rd_busy, o_fw_ready;
  logic        o_rd_strobe, o_low_power, o_prog_start, o_erase_start;
  logic        o_prog_pair, o_prog_busy, o_long_program_timing, o_prefetch_on;
  logic [7:0]  i_sfr_addr = 0, i_sfr_page = 0, i_sfr_wdata = 0;
  logic [7:0]  i_fw_data = 0, o_sfr_rdata, d0, d1;
  logic [15:0] i_fw_addr = 0, o_prog_addr, o_prog_data, a;
  logic [32:0] e, expq[$];
  wire  [7:0]  erases;
  int          err_total = 0, comparisons = 0, seed = 41587, n, k;
  flash_timing_cache_ctrl #(.SHORT_CYCLES(4), .LONG_CYCLES(8))
    u_flash_timing_cache_ctrl (.*);
  flash_array_model u_flash_array_model (.i_clk(i_clk),
    .i_prog_start(o_prog_start), .i_erase_start(o_erase_start),
    .i_prog_addr(o_prog_addr), .i_prog_data(o_prog_data),
    .i_prog_pair(o_prog_pair), .o_erases(erases));
  always #5 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  task sfr_wr(input [7:0] ad, pg, d);
    @(posedge i_clk);
    {i_sfr_addr, i_sfr_page, i_sfr_wdata, i_sfr_wr} <= {ad, pg, d, 1'b1};
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task sfr_rd(input [7:0] ad, pg, x);
    @(posedge i_clk);
    {i_sfr_addr, i_sfr_page} <= {ad, pg};
    repeat (2) @(posedge i_clk);
    #1 `CHK(o_sfr_rdata, x)
  endtask
  task rd(input int len);
    @(posedge i_clk);
    i_rd_req <= 1'b1;
    @(posedge i_clk);
    i_rd_req <= 1'b0;
    n = 0;
    repeat (4) begin
      #1 if (o_rd_strobe === 1'b1) n++;
      @(posedge i_clk);
    end
    `CHK(n, len)
  endtask
  // Waits for ready first; a held pair byte leaves ready high.
  task fw(input er, input [15:0] ad, input [7:0] d);
    @(posedge i_clk);
    repeat (20) if (o_fw_ready !== 1'b1) @(posedge i_clk);
    {i_erase_req, i_fw_wr, i_fw_addr, i_fw_data} <= {er, !er, ad, d};
    @(posedge i_clk);
    {i_erase_req, i_fw_wr} <= 2'b00;
  endtask
  always @(posedge i_clk) if (o_prog_start === 1'b1) begin
    e = expq.pop_front();
    `CHK({o_prog_pair, o_prog_addr, o_prog_data[7:0]}, {e[32:16], e[7:0]})
    if (e[32]) `CHK(o_prog_data[15:8], e[15:8])
  end
  task finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    sfr_rd(8'hB6, 8'h00, 8'h00);
    sfr_rd(8'hBE, 8'h0F, 8'h0F);
    sfr_rd(8'hE3, 8'h0F, 8'h20);
    sfr_rd(8'h55, 8'h0F, 8'h00);
    sfr_wr(8'hBE, 8'h0F, 8'hF0);
    sfr_rd(8'hBE, 8'h0F, 8'h00);
    sfr_wr(8'hE3, 8'h00, 8'h00);
    #1 `CHK(o_prefetch_on, 1'b1)
    sfr_wr(8'hE3, 8'h0F, 8'h00);
    #1 `CHK(o_prefetch_on, 1'b0)
    for (k = 0; k < 5; k++) begin
      sfr_wr(8'hB6, 8'h00, {3'h0, k != 0, 4'h0});
      sfr_wr(8'hBE, 8'h0F, {4'h0, k[1] ? {2'h0, k[0], 1'b1} : 4'hF});
      rd(k[1] ? 1 + (k > 2) : 1 + (k != 0));
    end
    for (k = 0; k < 4; k++) begin
      sfr_wr(8'hB6, 8'h00, {3'h0, 1'b1, 2'h0, k[0], 1'b0});
      sfr_wr(8'hE3, 8'h0F, {7'h00, k[1]});
      d0 = $random(seed);
      d1 = $random(seed);
      a = $random(seed);
      expq.push_back({k[1], a, d1, d0});
      fw(1'b0, a, d0);
      if (k[1]) fw(1'b0, a + 16'h0001, d1);
    end
    fw(1'b0, a, d1);
    fw(1'b1, a, 8'h00);
    expq.push_back({1'b1, a, d0, d1});
    fw(1'b0, a, d1);
    fw(1'b0, a + 16'h0001, d0);
    repeat (20) @(posedge i_clk);
    `CHK(erases, 8'h01)
    `CHK(expq.size(), 0)
    finish_test();
  end
endmodule // tb_flash_timing_cache_ctrl
